// >>> cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
	// Clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst,
	// Bench commands
	input  wire logic                         i_go,
	input  wire sys_reset_pkg::cpu_cycle_type i_cyc,
	input  wire logic                         i_master_req,
	input  wire logic                         i_local_master,
	// Device answers
	input  wire logic                         i_hold_req,
	input  wire logic                         i_ready_n,
	input  wire logic                         i_snoop_n,
	input  wire logic                         i_snoop_oe,
	// Processor and master pins
	output logic                              o_ads_n,
	output sys_reset_pkg::cpu_cycle_type      o_cycle,
	output logic                              o_hold_ack,
	output logic                              o_lm_ads_n,
	// Status for the bench
	output logic                              o_busy,
	output logic [4:0]                        o_lat,
	output logic [3:0]                        o_snoops
);
	logic [4:0] cnt_q; // Edges since the strobe was taken

	// Bus grant, local master strobes, snoop tally
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_hold_ack <= 1'b0;
			o_lm_ads_n <= 1'b1;
			o_snoops   <= 4'h0;
		end
		else
		begin
			o_hold_ack <= i_hold_req | i_master_req;
			// A local master strobes its own cycles
			o_lm_ads_n <= ~(i_local_master & o_hold_ack & o_lm_ads_n);
			// Each snoop hit adds one to the tally
			if (i_snoop_oe & ~i_snoop_n)
				o_snoops <= o_snoops + 4'h1;
		end
	end

	// One processor cycle: strobe for one clock, then wait for ready
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ads_n <= 1'b1;
			o_cycle <= '0;
			o_busy  <= 1'b0;
			o_lat   <= 5'h00;
			cnt_q   <= 5'h00;
		end
		else if (i_go)
		begin
			o_ads_n <= 1'b0;
			o_cycle <= i_cyc;
			o_busy  <= 1'b1;
			cnt_q   <= 5'h00;
		end
		else if (o_busy)
		begin
			o_ads_n <= 1'b1;
			// Released lines never keep the last value
			o_cycle <= ~o_cycle;
			cnt_q   <= cnt_q + 5'h01;
			// Give up after twenty edges; latency then reads zero
			if (!i_ready_n || cnt_q == 5'h14)
			begin
				o_busy <= 1'b0;
				o_lat  <= i_ready_n ? 5'h00 : cnt_q;
			end
		end
	end
endmodule
`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int unsigned     W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	// Clock and reset
	input  wire logic          i_sys_clk,
	input  wire logic          i_rst,
	// Raw pins and filtered result
	input  wire logic [W-1:0]  i_pin,
	output logic      [W-1:0]  o_level
);
	logic [W-1:0] s1_q;   // Metastability catcher
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;  // Second and third stage match

	assign agree = ~(s2_q ^ s3_q);

	// Three stages; a bit moves only when the last two agree
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			s1_q    <= INIT;
			s2_q    <= INIT;
			s3_q    <= INIT;
			o_level <= INIT;
		end
		else
		begin
			s1_q    <= i_pin;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			o_level <= (s3_q & agree) | (o_level & ~agree);
		end
endmodule
`default_nettype wire

// >>> reset_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module reset_pulse #(
	parameter int unsigned LEN = sys_reset_pkg::RESET_CYCLES
) (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// Trigger level and processor phase
	input  wire logic i_start,
	input  wire logic i_phase,
	// Pulse output
	output logic      o_active
);
	localparam int unsigned CW = $clog2(LEN) + 1;
	localparam logic [CW-1:0] LAST = CW'(LEN - 1);

	logic [CW-1:0] cnt_q;  // Cycles since last trigger

	// A held trigger keeps restarting, so the pulse outlasts it by LEN
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			// Leaving reset runs one full pulse, so the end stays phase aligned
			cnt_q    <= '0;
			o_active <= 1'b1;
		end
		else if (i_start)
		begin
			cnt_q    <= '0;
			o_active <= 1'b1;
		end
		else if (o_active)
		begin
			// End only in phase two; may stretch by one cycle
			if (cnt_q >= LAST && i_phase == sys_reset_pkg::PHASE_TWO)
				o_active <= 1'b0;
			else if (cnt_q < LAST)
				cnt_q <= cnt_q + CW'(1);
		end
endmodule
`default_nettype wire

// >>> sys_reset_misc_ctrl.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Turbo input high: never request hold
// - Turbo low: hold processor about two thirds
// - Keyboard select only for keyboard port cycles
// - NMI on parity error or enabled check
// - Drive tone timer gate
// - Speaker equals timer output and enable bit
// - Return ready after each processor cycle
// - Ready for each bus master memory access
// - Snoop strobe during bus master cycles
// - Drive write and memory select when snooping
// - Cold reset asserts all three resets
// - Resets end in processor phase two
// - Shutdown cycle asserts processor reset
// - Each reset lasts 128 master cycles
// - Keyboard FE command gives fast reset
// - Defer bit waits fast reset for halt
// - Coprocessor reset with processor reset, F1 write
module sys_reset_misc_ctrl #(
	parameter int unsigned CYCLE_WAIT  = 2,
	parameter int unsigned SLOT_CYCLES = 16
) (
	// Clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst,
	// Register port
	input  wire logic [3:0]                   i_reg_addr,
	input  wire logic [31:0]                  i_reg_wdata,
	input  wire logic                         i_reg_wr,
	input  wire logic                         i_reg_rd,
	output logic      [31:0]                  o_reg_rdata,
	// Processor bus
	input  wire logic                         i_cpu_ads_n,
	input  wire sys_reset_pkg::cpu_cycle_type i_cpu_cycle,
	input  wire logic                         i_hold_ack,
	input  wire logic                         i_local_master,
	input  wire logic                         i_parity_err,
	output logic                              o_ready_n,
	output logic                              o_hold_req,
	// Snoop pins, two-way
	input  wire logic                         i_addr_strobe_n,
	output logic                              o_addr_strobe_n,
	output logic                              o_addr_strobe_oe,
	output logic                              o_write_read,
	output logic                              o_mem_io_sel,
	output logic                              o_cycdef_oe,
	// Pins from outside the clock domain
	input  wire logic                         i_cold_reset_in_n,
	input  wire logic                         i_turbo,
	input  wire logic                         i_channel_check_n,
	input  wire logic                         i_tone_timer_out,
	input  wire logic                         i_at_mem_rd_n,
	input  wire logic                         i_at_mem_wr_n,
	// Resets out
	output logic                              o_proc_reset_out,
	output logic                              o_copro_reset_out,
	output logic                              o_sys_reset_out_n,
	// Peripheral controls
	output logic                              o_kbd_ctrl_select_n,
	output logic                              o_nmi,
	output logic                              o_tone_timer_gate,
	output logic                              o_speaker_out
);
	localparam logic [3:0] WAIT_LAST = 4'(CYCLE_WAIT - 1);
	localparam logic [7:0] SLOT_LAST = 8'(SLOT_CYCLES - 1);

	// Synchronised pin levels
	logic [5:0] pins;
	logic       cold_n_s;   // Cold reset, low active
	logic       turbo_s;    // Speed select
	logic       channel_check_n_n_s;   // Channel check, low active
	logic       tone_s;     // Tone timer output
	logic       rd_n_s;     // Master memory read command
	logic       wr_n_s;     // Master memory write command
	logic       rd_n_q;     // Previous command levels
	logic       wr_n_q;

	// Software state
	logic [2:0] ctrl_q;     // Gate, speaker enable, check enable
	logic [5:0] cfg_q;      // Coprocessor present, halt defer
	logic       parity_q;   // Sticky parity error

	// Processor cycle tracking
	logic       busy_q;     // Cycle waiting for ready
	logic [3:0] wait_q;     // Cycles left before ready
	logic       kbd_q;      // Keyboard select held
	logic       pend_q;     // Fast reset awaiting halt
	logic       phase_q;    // Processor clock phase
	logic [7:0] slot_cnt_q; // Cycles within a throttle slot
	logic [1:0] slot_q;     // Throttle slot, 0 to 2
	logic       mst_q;      // Master access start, delayed one cycle

	// Reset pulse generators
	logic       cold_act;
	logic       cpu_act;
	logic       f1_act;

	assign pins = {i_at_mem_wr_n, i_at_mem_rd_n, i_tone_timer_out,
		i_channel_check_n, i_turbo, i_cold_reset_in_n};

	pin_sync #(
		.W    (6),
		.INIT (sys_reset_pkg::PIN_INIT)
	) u_pins (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_pin     (pins),
		.o_level   ({wr_n_s, rd_n_s, tone_s, channel_check_n_n_s, turbo_s, cold_n_s})
	);

	// Processor cycle decode, valid only with the strobe
	wire cyc_valid  = !i_cpu_ads_n && !i_hold_ack;
	wire io_cyc     = cyc_valid && !i_cpu_cycle.mio && i_cpu_cycle.dc;
	wire io_wr      = io_cyc && i_cpu_cycle.wr;
	wire special    = cyc_valid && i_cpu_cycle.mio && !i_cpu_cycle.dc
		&& i_cpu_cycle.wr;
	wire shutdown   = special && !i_cpu_cycle.addr[1];
	wire halt       = special && i_cpu_cycle.addr[1];
	wire fast_cmd   = io_wr && i_cpu_cycle.addr == sys_reset_pkg::KBD_CMD_PORT
		&& i_cpu_cycle.data == sys_reset_pkg::FAST_RESET_CMD;
	// The reset command is swallowed, never reaches the keyboard part
	wire kbd_hit    = io_cyc && !fast_cmd
		&& (i_cpu_cycle.addr == sys_reset_pkg::KBD_DATA_PORT
		|| i_cpu_cycle.addr == sys_reset_pkg::KBD_CMD_PORT);
	wire f1_wr      = io_wr && i_cpu_cycle.addr == sys_reset_pkg::COPRO_PORT;
	wire defer      = cfg_q[sys_reset_pkg::CFG_HALT_DEFER];
	wire copro_en   = cfg_q[sys_reset_pkg::CFG_COPRO];
	wire fast_go    = (fast_cmd && !defer) || (pend_q && halt);
	wire cyc_done   = busy_q && wait_q == 4'h0;

	// Master command edges and snoop decision
	wire rd_fall    = rd_n_q && !rd_n_s;
	wire wr_fall    = wr_n_q && !wr_n_s;
	wire mst_start  = i_hold_ack && (rd_fall || wr_fall);
	wire snoop      = mst_start && !i_local_master;

	// Reset combination
	wire proc_rst_d  = cold_act || cpu_act;
	wire copro_rst_d = cold_act || (copro_en && (cpu_act || f1_act));

	// Throttle decision
	wire slot_tick  = slot_cnt_q == SLOT_LAST;
	wire hold_d     = !turbo_s && slot_q != 2'h2;

	// Register port decode
	wire sel_ctrl   = i_reg_addr == sys_reset_pkg::REG_SYS_CTRL;
	wire sel_cfg    = i_reg_addr == sys_reset_pkg::REG_CONFIG;
	wire sel_stat   = i_reg_addr == sys_reset_pkg::REG_STATUS;
	wire par_clr    = i_reg_wr && sel_stat
		&& i_reg_wdata[sys_reset_pkg::ST_PARITY];
	wire nmi_d      = parity_q || (!channel_check_n_n_s
		&& ctrl_q[sys_reset_pkg::CTRL_CHANNEL_CHECK_N_EN]);

	// Status word
	wire [7:0] status = {tone_s, pend_q, parity_q, o_nmi, turbo_s,
		!o_sys_reset_out_n, o_copro_reset_out, o_proc_reset_out};

	// Read selection, unmapped words read zero
	wire [31:0] rd_mux =
		sel_ctrl ? {29'h0, ctrl_q} :
		sel_cfg  ? {26'h0, cfg_q} :
		sel_stat ? {24'h0, status} :
		32'h0;

	// Cold reset pulse
	reset_pulse u_cold (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_start   (!cold_n_s),
		.i_phase   (phase_q),
		.o_active  (cold_act)
	);

	// Shutdown and fast command pulse
	reset_pulse u_cpu (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_start   (shutdown || fast_go),
		.i_phase   (phase_q),
		.o_active  (cpu_act)
	);

	// Coprocessor port pulse
	reset_pulse u_f1 (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_start   (f1_wr),
		.i_phase   (phase_q),
		.o_active  (f1_act)
	);

	// Phase follows the processor's divide by two from reset
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			phase_q <= 1'b0;
		else
			phase_q <= ~phase_q;

	// Reset outputs, all through the phase aligned pulses
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			o_proc_reset_out  <= 1'b1;
			o_copro_reset_out <= 1'b1;
			o_sys_reset_out_n <= 1'b0;
		end
		else
		begin
			o_proc_reset_out  <= proc_rst_d;
			o_copro_reset_out <= copro_rst_d;
			o_sys_reset_out_n <= !cold_act;
		end

	// Deferred fast reset; a new command wins over the halt clear
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			pend_q <= 1'b0;
		else if (fast_cmd && defer)
			pend_q <= 1'b1;
		else if (halt)
			pend_q <= 1'b0;

	// Cycle timer; a strobe while busy is not expected
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
		end
		else if (cyc_valid)
		begin
			busy_q <= 1'b1;
			wait_q <= WAIT_LAST;
		end
		else if (cyc_done)
			busy_q <= 1'b0;
		else if (busy_q)
			wait_q <= wait_q - 4'h1;

	// Keyboard select held for the whole cycle
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			kbd_q <= 1'b0;
		else if (kbd_hit)
			kbd_q <= 1'b1;
		else if (cyc_done)
			kbd_q <= 1'b0;

	// Master command edge memory
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			mst_q  <= 1'b0;
		end
		else
		begin
			rd_n_q <= rd_n_s;
			wr_n_q <= wr_n_s;
			mst_q  <= mst_start;
		end

	// Ready and snoop pins; a local master drives its own
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			o_ready_n        <= 1'b1;
			o_addr_strobe_n  <= 1'b1;
			o_addr_strobe_oe <= 1'b0;
			o_write_read     <= 1'b0;
			o_mem_io_sel     <= 1'b0;
			o_cycdef_oe      <= 1'b0;
		end
		else
		begin
			o_ready_n        <= !(cyc_done || mst_q);
			o_addr_strobe_n  <= !snoop;
			o_addr_strobe_oe <= snoop;
			o_write_read     <= snoop && wr_fall;
			o_mem_io_sel     <= snoop;
			o_cycdef_oe      <= snoop;
		end

	// Throttle slots, one enable pulse per slot
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			slot_cnt_q <= 8'h0;
			slot_q     <= 2'h0;
		end
		else if (slot_tick)
		begin
			slot_cnt_q <= 8'h0;
			slot_q     <= (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
		end
		else
			slot_cnt_q <= slot_cnt_q + 8'h1;

	// Hold request and peripheral outputs
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			o_hold_req          <= 1'b0;
			o_kbd_ctrl_select_n <= 1'b1;
			o_nmi               <= 1'b0;
			o_tone_timer_gate   <= 1'b0;
			o_speaker_out       <= 1'b0;
		end
		else
		begin
			o_hold_req          <= hold_d;
			o_kbd_ctrl_select_n <= !(kbd_hit || (kbd_q && !cyc_done));
			o_nmi               <= nmi_d;
			o_tone_timer_gate   <= ctrl_q[sys_reset_pkg::CTRL_TONE_GATE];
			o_speaker_out       <= tone_s
				&& ctrl_q[sys_reset_pkg::CTRL_SPEAKER_OUT_EN];
		end

	// Parity flag: a new error wins over a software clear
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			parity_q <= 1'b0;
		else if (i_parity_err)
			parity_q <= 1'b1;
		else if (par_clr)
			parity_q <= 1'b0;

	// Register writes
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			ctrl_q <= sys_reset_pkg::CTRL_RESET;
			cfg_q  <= sys_reset_pkg::CFG_RESET;
		end
		else if (i_reg_wr && sel_ctrl)
			ctrl_q <= i_reg_wdata[2:0];
		else if (i_reg_wr && sel_cfg)
			cfg_q  <= i_reg_wdata[5:0];

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			o_reg_rdata <= 32'h0;
		else
			o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;

	// Helper: length of the current processor reset
	logic [7:0] len_q;
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			len_q <= 8'h0;
		else if (!o_proc_reset_out)
			len_q <= 8'h0;
		else if (len_q != 8'hff)
			len_q <= len_q + 8'h1;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	property p_turbo;
		$past(turbo_s) |-> !o_hold_req;
	endproperty
	a_turbo: assert property (p_turbo) else $error("hold in turbo");

	property p_slot;
		$past(!turbo_s) && $past(slot_q) == 2'h2 |-> !o_hold_req;
	endproperty
	a_slot: assert property (p_slot) else $error("hold in free slot");

	property p_kbd;
		$fell(o_kbd_ctrl_select_n) |-> $past(kbd_hit);
	endproperty
	a_kbd: assert property (p_kbd) else $error("stray keyboard select");

	property p_nmi;
		$past(!channel_check_n_n_s && ctrl_q[sys_reset_pkg::CTRL_CHANNEL_CHECK_N_EN]) |-> o_nmi;
	endproperty
	a_nmi: assert property (p_nmi) else $error("missing nmi");

	property p_speaker_out;
		o_speaker_out |-> $past(tone_s);
	endproperty
	a_speaker_out: assert property (p_speaker_out) else $error("speaker without tone");

	property p_ready;
		cyc_valid |-> ##[1:16] !o_ready_n;
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing");

	property p_snoop;
		snoop |=> !o_addr_strobe_n && o_addr_strobe_oe && o_cycdef_oe
			&& o_mem_io_sel ##1 !o_ready_n;
	endproperty
	a_snoop: assert property (p_snoop) else $error("snoop incomplete");

	property p_cold;
		!cold_n_s |-> ##[1:3] o_proc_reset_out && o_copro_reset_out
			&& !o_sys_reset_out_n;
	endproperty
	a_cold: assert property (p_cold) else $error("cold reset missed");

	property p_phase;
		$fell(o_proc_reset_out) |-> $past(phase_q, 2) == sys_reset_pkg::PHASE_TWO;
	endproperty
	a_phase: assert property (p_phase) else $error("reset ends in phase one");

	property p_len;
		$fell(o_proc_reset_out) |-> $past(len_q) >= 8'(sys_reset_pkg::RESET_CYCLES - 1);
	endproperty
	a_len: assert property (p_len) else $error("reset too short");

	property p_fast;
		fast_cmd && !defer |=> o_kbd_ctrl_select_n ##[0:2] o_proc_reset_out;
	endproperty
	a_fast: assert property (p_fast) else $error("fast reset missed");

	property p_f1;
		f1_wr && copro_en |-> ##[1:3] o_copro_reset_out;
	endproperty
	a_f1: assert property (p_f1) else $error("coprocessor reset missed");

	c_fast_defer: cover property (pend_q && halt ##[1:3] o_proc_reset_out);
	c_slow: cover property (!turbo_s && o_hold_req);
	c_snoop: cover property (snoop ##2 !o_ready_n);
	c_shutdown: cover property (shutdown ##[1:3] o_proc_reset_out);
endmodule
`default_nettype wire

// >>> sys_reset_pkg.sv
package sys_reset_pkg;

	// Register word offsets (byte addresses)
	localparam logic [3:0] REG_SYS_CTRL = 4'h0;
	localparam logic [3:0] REG_CONFIG   = 4'h4;
	localparam logic [3:0] REG_STATUS   = 4'h8;

	// System control field positions
	localparam int unsigned CTRL_TONE_GATE = 0;
	localparam int unsigned CTRL_SPEAKER_OUT_EN   = 1;
	localparam int unsigned CTRL_CHANNEL_CHECK_N_EN   = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h0;

	// Configuration field positions
	localparam int unsigned CFG_COPRO      = 0;
	localparam int unsigned CFG_HALT_DEFER = 5;
	localparam logic [5:0]  CFG_RESET      = 6'h00;

	// Status field positions
	localparam int unsigned ST_PROC_RST   = 0;
	localparam int unsigned ST_COPRO_RST  = 1;
	localparam int unsigned ST_SYS_RST    = 2;
	localparam int unsigned ST_TURBO      = 3;
	localparam int unsigned ST_NMI        = 4;
	localparam int unsigned ST_PARITY     = 5;
	localparam int unsigned ST_FAST_PEND  = 6;
	localparam int unsigned ST_TONE       = 7;

	// Decoded I/O ports and command value
	localparam logic [15:0] KBD_DATA_PORT  = 16'h0060;
	localparam logic [15:0] KBD_CMD_PORT   = 16'h0064;
	localparam logic [15:0] COPRO_PORT     = 16'h00f1;
	localparam logic [7:0]  FAST_RESET_CMD = 8'hfe;

	// Reset pulse length in master clock cycles
	localparam int unsigned RESET_CYCLES = 128;
	// Processor clock phase in which resets may end
	localparam logic        PHASE_TWO    = 1'b1;

	// Synchroniser rest values: {wr_n, rd_n, tone, channel_check_n_n, turbo, cold_n}
	localparam logic [5:0]  PIN_INIT     = 6'h37;

	// Processor bus cycle, sampled with the address strobe
	typedef struct packed {
		logic        mio;
		logic        dc;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} cpu_cycle_type;

endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned WAITS = 2; // Processor wait count
	localparam int unsigned SLOT  = 4; // Short slot keeps the run brief
	localparam logic [2:0]  IOR   = 3'h2; // Codes as {mio, dc, wr}
	localparam logic [2:0]  IOW   = 3'h3;
	localparam logic [2:0]  HLT   = 3'h5;
	// Stimulus
	logic        clk, rst, wr, rd, go, mreq, lmast, perr, tone;
	logic        cold_n, turbo, channel_check_n_n, mrd_n, mwr_n;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, v;
	sys_reset_pkg::cpu_cycle_type cyc, cycle;
	// Observed outputs
	logic        ads_n, hack, rdy_n, hreq, s_n, s_oe, wrd, mio, cd_oe, lm_n, busy;
	logic        prst, crst, srst_n, kbd_n, nmi, gate, speaker_out, prev_rst;
	logic [4:0]  lat;
	logic [3:0]  snoops;
	int          err_count, cmp_count, ecnt, take_at, rise_at, fall_at;
	int          sel_cnt, rdy_cnt, oe_cnt, hold_cnt;
	// Strobe pin: device when enabled, else the master side
	wire logic   strobe_w = s_oe ? s_n : lm_n;

	sys_reset_misc_ctrl #(.CYCLE_WAIT(WAITS), .SLOT_CYCLES(SLOT)) i_sys_reset_misc_ctrl (
		.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cpu_ads_n(ads_n),
		.i_cpu_cycle(cycle), .i_hold_ack(hack), .i_local_master(lmast),
		.i_parity_err(perr), .o_ready_n(rdy_n), .o_hold_req(hreq),
		.i_addr_strobe_n(strobe_w), .o_addr_strobe_n(s_n), .o_addr_strobe_oe(s_oe),
		.o_write_read(wrd), .o_mem_io_sel(mio), .o_cycdef_oe(cd_oe),
		.i_cold_reset_in_n(cold_n), .i_turbo(turbo), .i_channel_check_n(channel_check_n_n),
		.i_tone_timer_out(tone), .i_at_mem_rd_n(mrd_n), .i_at_mem_wr_n(mwr_n),
		.o_proc_reset_out(prst), .o_copro_reset_out(crst), .o_sys_reset_out_n(srst_n),
		.o_kbd_ctrl_select_n(kbd_n), .o_nmi(nmi), .o_tone_timer_gate(gate),
		.o_speaker_out(speaker_out));

	cpu_bus_model i_cpu_bus_model (
		.i_sys_clk(clk), .i_rst(rst), .i_go(go), .i_cyc(cyc), .i_master_req(mreq),
		.i_local_master(lmast), .i_hold_req(hreq), .i_ready_n(rdy_n), .i_snoop_n(s_n),
		.i_snoop_oe(s_oe), .o_ads_n(ads_n), .o_cycle(cycle), .o_hold_ack(hack),
		.o_lm_ads_n(lm_n), .o_busy(busy), .o_lat(lat), .o_snoops(snoops));

	// Free running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Edge stamps and event tallies, sampled before the edge updates land
	always @(posedge clk)
	begin
		ecnt <= ecnt + 1;
		prev_rst <= prst;
		if (ads_n === 1'b0) take_at <= ecnt;
		if (prst === 1'b1 && prev_rst === 1'b0) rise_at <= ecnt;
		if (prst === 1'b0 && prev_rst === 1'b1) fall_at <= ecnt;
		sel_cnt <= sel_cnt + int'(kbd_n === 1'b0);
		rdy_cnt <= rdy_cnt + int'(rdy_n === 1'b0);
		oe_cnt <= oe_cnt + int'(s_oe === 1'b1);
		hold_cnt <= hold_cnt + int'(hreq === 1'b1);
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task end_sim;
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	// One processor cycle through the bus model, bounded wait
	task cpu(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= {k, a, d};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
	endtask

	// Both resets idle, bounded well past one pulse
	task wait_idle;
		int n;
		n = 0;
		while ((prst | crst) !== 1'b0 && n < 400)
		begin
			tick(1);
			n++;
		end
		tick(2);
	endtask

	task t_regs;
		rreg(sys_reset_pkg::REG_CONFIG, v);
		chk(v, 32'h0);
		wreg(sys_reset_pkg::REG_SYS_CTRL, 32'hffffffff);
		rreg(sys_reset_pkg::REG_SYS_CTRL, v);
		chk(v, 32'h7);
		wreg(4'hc, 32'hffffffff);
		rreg(4'hc, v);
		chk(v, 32'h0);
		tone <= 1'b1;
		tick(6);
		chk(gate, 1'b1);
		chk(speaker_out, 1'b1);
		wreg(sys_reset_pkg::REG_SYS_CTRL, 32'h1);
		tick(3);
		chk(speaker_out, 1'b0);
		chk(gate, 1'b1);
		tone <= 1'b0;
	endtask

	// Two keyboard ports select, two others do not
	task t_kbd;
		logic [15:0] port [4] = '{sys_reset_pkg::KBD_DATA_PORT,
			sys_reset_pkg::KBD_CMD_PORT, 16'h0080, sys_reset_pkg::COPRO_PORT};
		int s;
		for (int i = 0; i < 4; i++)
		begin
			s = sel_cnt;
			cpu(IOR, port[i], 8'h00);
			chk(lat, WAITS + 1);
			chk(sel_cnt - s, (i < 2) ? WAITS : 0);
		end
	endtask

	task t_nmi;
		perr <= 1'b1;
		tick(1);
		perr <= 1'b0;
		tick(2);
		chk(nmi, 1'b1);
		rreg(sys_reset_pkg::REG_STATUS, v);
		chk(v[sys_reset_pkg::ST_PARITY], 1'b1);
		wreg(sys_reset_pkg::REG_STATUS, 32'h20);
		wreg(sys_reset_pkg::REG_SYS_CTRL, 32'h0);
		channel_check_n_n <= 1'b0;
		tick(8);
		chk(nmi, 1'b0);
		wreg(sys_reset_pkg::REG_SYS_CTRL, 32'h4);
		tick(2);
		chk(nmi, 1'b1);
		channel_check_n_n <= 1'b1;
	endtask

	// Cold reset released on either edge parity must end on the same phase
	task t_cold;
		logic [1:0] par;
		int s;
		for (int d = 0; d < 2; d++)
		begin
			cold_n <= 1'b0;
			tick(8);
			chk(prst, 1'b1);
			chk(crst, 1'b1);
			chk(srst_n, 1'b0);
			while (ecnt[0] !== d[0]) tick(1);
			cold_n <= 1'b1;
			s = ecnt;
			wait_idle;
			chk(fall_at - s >= 128 && fall_at - s <= 140, 1);
			par[d] = fall_at[0];
		end
		chk(par[0], par[1]);
	endtask

	// Strobe stamped at its taking edge, reset seen high two edges on
	task t_fast;
		int s;
		s = sel_cnt;
		cpu(IOW, sys_reset_pkg::KBD_CMD_PORT, sys_reset_pkg::FAST_RESET_CMD);
		chk(rise_at - take_at, 2);
		chk(sel_cnt - s, 0);
		chk(crst, 1'b0);
		wait_idle;
		chk(fall_at - rise_at >= 128 && fall_at - rise_at <= 130, 1);
		wreg(sys_reset_pkg::REG_CONFIG, 32'h20);
		cpu(IOW, sys_reset_pkg::KBD_CMD_PORT, sys_reset_pkg::FAST_RESET_CMD);
		tick(8);
		chk(prst, 1'b0);
		rreg(sys_reset_pkg::REG_STATUS, v);
		chk(v[sys_reset_pkg::ST_FAST_PEND], 1'b1);
		cpu(HLT, 16'h0002, 8'h00);
		chk(rise_at - take_at, 2);
		wait_idle;
		cpu(HLT, 16'h0000, 8'h00);
		chk(rise_at - take_at, 2);
		wait_idle;
		wreg(sys_reset_pkg::REG_CONFIG, 32'h1);
		cpu(IOW, sys_reset_pkg::COPRO_PORT, 8'h00);
		chk(crst, 1'b1);
		chk(prst, 1'b0);
		wait_idle;
		cpu(HLT, 16'h0000, 8'h00);
		chk(crst, 1'b1);
		wait_idle;
	endtask

	// Whole periods only, so the phase of the slot counter drops out
	task t_turbo;
		int s;
		s = hold_cnt;
		tick(24);
		chk(hold_cnt - s, 0);
		turbo <= 1'b0;
		tick(8);
		s = hold_cnt;
		tick(6 * SLOT);
		chk(hold_cnt - s, 4 * SLOT);
		turbo <= 1'b1;
		tick(8);
	endtask

	// Write and read snoops, then a local master that drives its own lines
	task t_snoop;
		int n, r, o;
		mreq <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			lmast <= (k == 2);
			tick(4);
			r = rdy_cnt;
			o = oe_cnt;
			if (k == 1) mrd_n <= 1'b0;
			else mwr_n <= 1'b0;
			n = 0;
			while (s_oe !== 1'b1 && n < 12)
			begin
				tick(1);
				n++;
			end
			if (k < 2)
			begin
				chk(s_n, 1'b0);
				chk(mio, 1'b1);
				chk(wrd, k == 0);
				chk(cd_oe, 1'b1);
			end
			tick(10);
			chk(rdy_cnt - r, 1);
			chk(oe_cnt - o, k < 2);
			mrd_n <= 1'b1;
			mwr_n <= 1'b1;
		end
		chk(snoops, 4'h2);
		mreq <= 1'b0;
		lmast <= 1'b0;
		tick(4);
	endtask

	// Main sequence
	initial
	begin
		{wr, rd, go, mreq, lmast, perr, tone} = '0;
		{cold_n, turbo, channel_check_n_n, mrd_n, mwr_n} = '1;
		addr = '0;
		wdata = '0;
		cyc = '0;
		rst = 1'b1;
		tick(6);
		rst <= 1'b0;
		tick(4);
		t_regs;
		t_kbd;
		t_nmi;
		t_cold;
		t_fast;
		t_turbo;
		t_snoop;
		end_sim;
	end

	// Watchdog, several times the expected run
	initial
	begin
		#200000;
		err_count++;
		end_sim;
	end
endmodule
`default_nettype wire
